// ===== verilog/acs_params.svh
// register offsets, field positions, reset values and timing counts
// included by the package and the testbench; definitions only
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
// byte offsets on the register bus
`define ACS_OFS_LEN    8'h00
`define ACS_OFS_RATE   8'h04
`define ACS_OFS_G13    8'h08
`define ACS_OFS_OFF3   8'h0C
`define ACS_OFS_CTRL   8'h10
`define ACS_OFS_RES    8'h14
// field positions
`define ACS_POS_START  7
`define ACS_POS_NEXP   5
`define ACS_POS_REXP   2
`define ACS_POS_CONT   1
`define ACS_POS_FS     6
`define ACS_POS_G2     4
`define ACS_POS_G1     7
`define ACS_POS_BUSY   7
`define ACS_POS_DEF    6
// reset and restore values
`define ACS_DEF_NEXP   2'h1
`define ACS_DEF_REXP   3'h2
`define ACS_DEF_FS     2'h0
`define ACS_DEF_G3     7'h0C
// over-sampling periods spent opening and closing a conversion
`define ACS_PRE_TICKS  11'h002
`define ACS_POST_TICKS 11'h002
`endif

// ===== verilog/acs_pkg.sv
// types shared by the conversion sequencer
// assumes acs_params.svh is on the include path
package acs_pkg;
  `include "acs_params.svh"
  // live or latched conversion settings
  typedef struct packed {
    logic       cont;  // continuous mode
    logic [1:0] nexp;  // elem_count_exponent
    logic [2:0] rexp;  // ratio_exponent
    logic [1:0] fs;    // sample_rate_sel
    logic       g1;    // stage1_gain_sel
    logic [1:0] g2;    // stage2_gain_sel
    logic [3:0] off2;  // stage2_offset_code
    logic [6:0] g3;    // stage3_gain_code
    logic [6:0] off3;  // stage3_offset_code
    logic [1:0] bg;    // bandgap mode
  } acs_cfg_t;
  // sequencer phases
  typedef enum logic [2:0] {
    S_IDLE, S_PRE, S_ELEM, S_QUANT, S_POST
  } acs_state_t;
endpackage

// ===== verilog/acs_sequencer.sv
// apb register file, amplifier code decode and conversion sequencer
// assumes a free-running 4 mhz oscillator on osc_4mhz and a modulator
// that posts one signed result per elementary conversion on elem_valid
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic        pclk,           // bus clock, 50 mhz
  input  wire logic        presetn,        // async reset, low
  input  wire logic [7:0]  paddr,          // apb byte address
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb access phase
  input  wire logic        pwrite,         // apb direction
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb unmapped access
  input  wire logic        osc_4mhz,       // oscillator pin
  input  wire logic [15:0] elem_data,      // elementary result
  input  wire logic        elem_valid,     // elementary result strobe
  output logic             stage1_x10,     // stage one gain ten
  output logic      [3:0]  stage2_gain,    // stage two gain value
  output logic             stage2_off_neg, // stage two offset sign
  output logic      [2:0]  stage2_off_mag, // offset in 0.2 steps
  output logic      [6:0]  stage3_gain,    // gain in twelfths
  output logic             stage3_off_neg, // stage three offset sign
  output logic      [5:0]  stage3_off_mag, // offset in twelfths
  output logic             fs_tick,        // over-sampling strobe
  output logic             elem_begin,     // elementary start strobe
  output logic             quant_go,       // final quantisation strobe
  output logic             chop_pol,       // offset chop polarity
  output logic             bandgap_hi,     // bandgap state
  output logic             busy,           // conversion running
  output logic             conv_done,      // conversion end strobe
  output logic      [15:0] result          // averaged result
);

  acs_cfg_t       cfg_r;        // live settings
  acs_cfg_t       lat_r;        // settings of running conversion
  acs_cfg_t       go_cfg;       // settings taken at start
  acs_cfg_t       def_cfg;      // restore values
  acs_state_t     st_r;         // sequencer phase
  acs_state_t     st_nxt;       // next phase
  logic [31:0]    prdata_r;     // read data register
  logic           pready_r;     // ready register
  logic           pslverr_r;    // error register
  logic [31:0]    rd_nxt;       // read mux
  logic           hit;          // address is mapped
  logic           wr_en;        // write takes effect
  logic           def_wr;       // restore bit written
  logic           start_wr;     // start or continuous set written
  logic           pend_r;       // queued start
  logic           go;           // conversion begins this cycle
  logic [2:0]     osc_s_r;      // oscillator synchroniser
  logic           osc_lvl_r;    // filtered oscillator level
  logic           osc_edge;     // filtered rising edge
  logic [5:0]     div_r;        // oscillator divider
  logic [5:0]     div_lim;      // divider terminal count
  logic           fs_tick_r;    // over-sampling strobe
  logic [10:0]    tick_r;       // periods within phase
  logic [10:0]    osr_val;      // oversampling_ratio
  logic [3:0]     elem_r;       // elementary index
  logic [3:0]     elem_last;    // last elementary index
  logic           ph_end;       // phase ends at this tick
  logic           elem_next;    // next elementary conversion
  logic           post_end;     // conversion ends
  logic signed [18:0] acc_r;    // sum of elementary results
  logic           elem_begin_r; // elementary start strobe
  logic           quant_r;      // quantisation strobe
  logic           chop_r;       // chop polarity
  logic           bg_r;         // bandgap state
  logic           busy_r;       // busy flag
  logic           done_r;       // done strobe
  logic [15:0]    result_r;     // averaged result
  logic           s1x10_r;      // decoded stage one gain
  logic [3:0]     s2g_r;        // decoded stage two gain
  logic           s2n_r;        // stage two sign
  logic [2:0]     s2m_r;        // stage two magnitude
  logic [6:0]     s3g_r;        // stage three gain
  logic           s3n_r;        // stage three sign
  logic [5:0]     s3m_r;        // stage three magnitude

  // restore values
  always_comb begin
    def_cfg      = '0;
    def_cfg.nexp = `ACS_DEF_NEXP;
    def_cfg.rexp = `ACS_DEF_REXP;
    def_cfg.fs   = `ACS_DEF_FS;
    def_cfg.g3   = `ACS_DEF_G3;
  end

  // bus decode
  assign wr_en    = psel & penable & pready_r & pwrite;
  assign def_wr   = wr_en & (paddr == `ACS_OFS_CTRL) & pwdata[`ACS_POS_DEF];
  assign start_wr = wr_en & (paddr == `ACS_OFS_LEN) &
                    (pwdata[`ACS_POS_START] | pwdata[`ACS_POS_CONT]);

  // read mux, start and restore bits read zero
  always_comb begin
    rd_nxt = '0;
    hit    = 1'b1;
    case (paddr)
      `ACS_OFS_LEN: begin
        rd_nxt[`ACS_POS_NEXP+:2] = cfg_r.nexp;
        rd_nxt[`ACS_POS_REXP+:3] = cfg_r.rexp;
        rd_nxt[`ACS_POS_CONT]    = cfg_r.cont;
      end
      `ACS_OFS_RATE: rd_nxt[7:0] = {cfg_r.fs, cfg_r.g2, cfg_r.off2};
      `ACS_OFS_G13:  rd_nxt[7:0] = {cfg_r.g1, cfg_r.g3};
      `ACS_OFS_OFF3: rd_nxt[6:0] = cfg_r.off3;
      `ACS_OFS_CTRL: begin
        rd_nxt[`ACS_POS_BUSY] = busy_r;
        rd_nxt[1:0]           = cfg_r.bg;
      end
      `ACS_OFS_RES:  rd_nxt[15:0] = result_r;
      default:       hit = 1'b0;
    endcase
  end

  // apb answer, one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~hit;
      if (psel & ~penable) begin
        prdata_r <= rd_nxt;
      end
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r      <= '0;
      cfg_r.nexp <= `ACS_DEF_NEXP;
      cfg_r.rexp <= `ACS_DEF_REXP;
      cfg_r.g3   <= `ACS_DEF_G3;
    end else if (def_wr) begin
      cfg_r <= def_cfg;
    end else if (wr_en) begin
      case (paddr)
        `ACS_OFS_LEN: begin
          cfg_r.nexp <= pwdata[`ACS_POS_NEXP+:2];
          cfg_r.rexp <= pwdata[`ACS_POS_REXP+:3];
          cfg_r.cont <= pwdata[`ACS_POS_CONT];
        end
        `ACS_OFS_RATE: begin
          cfg_r.fs   <= pwdata[`ACS_POS_FS+:2];
          cfg_r.g2   <= pwdata[`ACS_POS_G2+:2];
          cfg_r.off2 <= pwdata[3:0];
        end
        `ACS_OFS_G13: begin
          cfg_r.g1 <= pwdata[`ACS_POS_G1];
          cfg_r.g3 <= pwdata[6:0];
        end
        `ACS_OFS_OFF3: cfg_r.off3 <= pwdata[6:0];
        `ACS_OFS_CTRL: cfg_r.bg   <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // queued start waits for the running conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b0;
    end else if (start_wr) begin
      pend_r <= 1'b1;
    end else if (go) begin
      pend_r <= 1'b0;
    end
  end

  // oscillator pin: three flops, change counts when two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s_r   <= '0;
      osc_lvl_r <= 1'b0;
    end else begin
      osc_s_r <= {osc_s_r[1:0], osc_4mhz};
      if (osc_s_r[1] == osc_s_r[2]) begin
        osc_lvl_r <= osc_s_r[2];
      end
    end
  end
  assign osc_edge = (osc_s_r[1] == osc_s_r[2]) & osc_s_r[2] & ~osc_lvl_r;

  // over-sampling divider: 64, 32, 16 or 8 oscillator periods
  assign div_lim = 6'((7'h40 >> lat_r.fs) - 7'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r     <= '0;
      fs_tick_r <= 1'b0;
    end else begin
      fs_tick_r <= osc_edge & (div_r >= div_lim);
      if (osc_edge) begin
        div_r <= (div_r >= div_lim) ? 6'h00 : div_r + 6'h01;
      end
    end
  end

  // sequence arithmetic
  assign osr_val   = 11'(11'h008 << lat_r.rexp);
  assign elem_last = 4'((5'h01 << lat_r.nexp) - 5'h01);
  assign go_cfg    = def_wr ? def_cfg : cfg_r;

  // phase ends
  always_comb begin
    ph_end = 1'b0;
    case (st_r)
      S_PRE:   ph_end = (tick_r == `ACS_PRE_TICKS - 11'h001);
      S_ELEM:  ph_end = (tick_r == osr_val);
      S_QUANT: ph_end = 1'b1;
      S_POST:  ph_end = (tick_r == `ACS_POST_TICKS - 11'h001);
      default: ph_end = 1'b0;
    endcase
  end
  assign elem_next = fs_tick_r & ph_end & (st_r == S_ELEM) &
                     (elem_r != elem_last);
  assign post_end  = fs_tick_r & ph_end & (st_r == S_POST);
  // restore aborts at once; a start waits for idle or the end
  assign go = def_wr | ((st_r == S_IDLE) & pend_r) |
              (post_end & (pend_r | cfg_r.cont));

  // next phase
  always_comb begin
    st_nxt = st_r;
    if (go) begin
      st_nxt = S_PRE;
    end else if (fs_tick_r & ph_end) begin
      case (st_r)
        S_PRE:   st_nxt = S_ELEM;
        S_ELEM:  st_nxt = (elem_r == elem_last) ? S_QUANT : S_ELEM;
        S_QUANT: st_nxt = S_POST;
        S_POST:  st_nxt = S_IDLE;
        default: st_nxt = S_IDLE;
      endcase
    end
  end

  // phase register and busy flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= S_IDLE;
      busy_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      busy_r <= (st_nxt != S_IDLE);
    end
  end

  // settings latched at start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_r      <= '0;
      lat_r.nexp <= `ACS_DEF_NEXP;
      lat_r.rexp <= `ACS_DEF_REXP;
      lat_r.g3   <= `ACS_DEF_G3;
    end else if (go) begin
      lat_r <= go_cfg;
    end
  end

  // period and elementary counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r <= '0;
      elem_r <= '0;
    end else if (go) begin
      tick_r <= '0;
      elem_r <= '0;
    end else if (fs_tick_r) begin
      tick_r <= ph_end ? 11'h000 : tick_r + 11'h001;
      if (elem_next) begin
        elem_r <= elem_r + 4'h1;
      end
    end
  end

  // strobes toward the modulator and the conversion end strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elem_begin_r <= 1'b0;
      quant_r      <= 1'b0;
      done_r       <= 1'b0;
    end else begin
      elem_begin_r <= ~go & fs_tick_r & ph_end &
                      ((st_r == S_PRE) | elem_next);
      quant_r      <= ~go & (st_r != S_QUANT) & (st_nxt == S_QUANT);
      done_r       <= post_end & ~def_wr;
    end
  end

  // chop polarity and bandgap state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_r <= 1'b0;
      bg_r   <= 1'b0;
    end else if (go) begin
      chop_r <= 1'b0;
      bg_r   <= (go_cfg.bg == 2'h1);
    end else if (elem_next) begin
      chop_r <= ~chop_r;
      case (lat_r.bg)
        2'h2:    bg_r <= ~bg_r;
        2'h3:    bg_r <= elem_r[0] ? ~bg_r : bg_r;
        2'h1:    bg_r <= 1'b1;
        default: bg_r <= 1'b0;
      endcase
    end
  end

  // accumulate and average elementary results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r    <= '0;
      result_r <= '0;
    end else if (go) begin
      acc_r <= '0;
    end else begin
      if (elem_valid & ((st_r == S_ELEM) | (st_r == S_QUANT))) begin
        acc_r <= acc_r + 19'(signed'(elem_data));
      end
      if (fs_tick_r & (st_r == S_QUANT)) begin
        result_r <= 16'(acc_r >>> lat_r.nexp);
      end
    end
  end

  // amplifier code decode from latched settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1x10_r <= 1'b0;
      s2g_r   <= 4'h1;
      s2n_r   <= 1'b0;
      s2m_r   <= '0;
      s3g_r   <= '0;
      s3n_r   <= 1'b0;
      s3m_r   <= '0;
    end else begin
      s1x10_r <= lat_r.g1;
      case (lat_r.g2)
        2'h0:    s2g_r <= 4'h1;
        2'h1:    s2g_r <= 4'h2;
        2'h2:    s2g_r <= 4'h5;
        default: s2g_r <= 4'hA;
      endcase
      s2n_r <= lat_r.off2[3];
      // magnitudes past one are clipped to one
      s2m_r <= (lat_r.off2[2:0] > 3'h5) ? 3'h5 : lat_r.off2[2:0];
      s3g_r <= lat_r.g3;
      s3n_r <= lat_r.off3[6];
      s3m_r <= lat_r.off3[5:0];
    end
  end

  // outputs
  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign stage1_x10     = s1x10_r;
  assign stage2_gain    = s2g_r;
  assign stage2_off_neg = s2n_r;
  assign stage2_off_mag = s2m_r;
  assign stage3_gain    = s3g_r;
  assign stage3_off_neg = s3n_r;
  assign stage3_off_mag = s3m_r;
  assign fs_tick        = fs_tick_r;
  assign elem_begin     = elem_begin_r;
  assign quant_go       = quant_r;
  assign chop_pol       = chop_r;
  assign bandgap_hi     = bg_r;
  assign busy           = busy_r;
  assign conv_done      = done_r;
  assign result         = result_r;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_busy_phase: assert property (
    busy_r == (st_r != S_IDLE)) else $error("busy disagrees with phase");
  a_start_zero: assert property (
    (pready_r & (paddr == `ACS_OFS_LEN)) |-> !prdata_r[`ACS_POS_START])
    else $error("start bit read back set");
  a_def_restart: assert property (
    def_wr |=> (st_r == S_PRE) && (tick_r == 11'h000) &&
    (lat_r.rexp == `ACS_DEF_REXP)) else $error("restore did not restart");
  a_start_waits: assert property (
    (start_wr & (st_r == S_IDLE) & !def_wr) |=> ##1 (st_r == S_PRE))
    else $error("start from idle not taken");
  a_elem_length: assert property (
    (st_r == S_ELEM) |-> (tick_r <= osr_val))
    else $error("elementary conversion overran");
  a_chop_toggle: assert property (
    (elem_next & !go) |=> (chop_r != $past(chop_r)))
    else $error("chop did not alternate");
  a_gain2_five: assert property (
    (lat_r.g2 == 2'h2) |=> (s2g_r == 4'h5) || $changed(lat_r))
    else $error("stage two gain code 2 not five");
  a_cfg_hold: assert property (
    !go |=> $stable(lat_r)) else $error("settings moved mid conversion");
  a_cont_again: assert property (
    (post_end & cfg_r.cont) |=> (st_r == S_PRE))
    else $error("continuous mode did not restart");
  a_div_tick: assert property (
    fs_tick_r |-> $past(div_r) == div_lim || $changed(lat_r))
    else $error("divider ticked early");

  c_restore_busy: cover property (def_wr & busy_r);
  c_cont_loop:    cover property (post_end & cfg_r.cont);
  c_queued_start: cover property (start_wr & busy_r);
  c_eight_elem:   cover property (elem_next & (elem_r == 4'h6));

endmodule

// ===== verification/acs_analog_model.sv
// partner model: 4 mhz oscillator and a modulator that posts one
// result per elementary conversion; assumes strobes on pclk
`timescale 1ns/1ps
module acs_analog_model (
  input  wire logic        pclk,       // bus clock
  input  wire logic        presetn,    // async reset, low
  input  wire logic        elem_begin, // elementary start strobe
  input  wire logic        quant_go,   // final step strobe
  input  wire logic        slow,       // answer late when high
  output logic             osc_4mhz,   // free-running oscillator
  output logic      [15:0] elem_data,  // elementary result
  output logic             elem_valid  // result strobe
);
  logic [3:0] idx_r;  // elementary index in this conversion
  int         wait_r; // cycles before posting, -1 idle
  // square wave unrelated in phase to pclk
  initial osc_4mhz = 1'b0;
  always #125 osc_4mhz = ~osc_4mhz;
  // post 0x100 plus 16 per index, promptly or late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r      <= 4'h0;
      wait_r     <= -1;
      elem_valid <= 1'b0;
      elem_data  <= 16'hA5A5;
    end else begin
      elem_valid <= 1'b0;
      elem_data  <= ~elem_data; // no stale value outside strobe
      if (quant_go) idx_r <= 4'h0;
      if (elem_begin) wait_r <= slow ? 60 : 1;
      else if (wait_r > 0) wait_r <= wait_r - 1;
      else if (wait_r == 0) begin
        elem_valid <= 1'b1;
        elem_data  <= 16'h0100 + {8'h00, idx_r, 4'h0};
        idx_r      <= idx_r + 4'h1;
        wait_r     <= -1;
      end
    end
  end
endmodule

// ===== verification/adc_conversion_sequencer_tb.sv
// bench for the conversion sequencer: apb registers, decode, timing
// assumes acs_params.svh on the include path and the partner model
`timescale 1ns/1ps
`include "acs_params.svh"
module adc_conversion_sequencer_tb;
  import acs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, slow; // drives
  logic [7:0]  paddr;  // apb address
  logic [31:0] pwdata; // apb write data
  logic [31:0] prdata; // apb read data
  logic        pready, pslverr, osc_4mhz, elem_valid;
  logic [15:0] elem_data, result;
  logic        stage1_x10, stage2_off_neg, stage3_off_neg;
  logic [3:0]  stage2_gain;
  logic [2:0]  stage2_off_mag;
  logic [6:0]  stage3_gain;
  logic [5:0]  stage3_off_mag;
  logic        fs_tick, elem_begin, quant_go, chop_pol, bandgap_hi;
  logic        busy, conv_done;
  int          err_total, checks; // mismatch and compare counts
  // 50 mhz clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  acs_sequencer dut (.*);
  acs_analog_model far (.pclk(pclk), .presetn(presetn),
    .elem_begin(elem_begin), .quant_go(quant_go), .slow(slow),
    .osc_4mhz(osc_4mhz), .elem_data(elem_data),
    .elem_valid(elem_valid));
  // count a compare, report a mismatch at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] rd, output logic se);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(pready, 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic se;
    apb(1'b1, a, d, rd, se);
  endtask
  // read and compare data and error flag
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
    input logic ee);
    logic [31:0] rd;
    logic se;
    apb(1'b0, a, 8'h00, rd, se);
    chk(rd, e);
    chk(se, ee);
  endtask
  // bounded wait: 0 busy, 1 conv_done, 2 elem_begin
  task automatic wait_on(input int sel, input int lim);
    int n;
    logic s;
    n = 0;
    do begin
      @(negedge pclk);
      s = sel == 0 ? busy : sel == 1 ? conv_done : elem_begin;
      n++;
    end while (s !== 1'b1 && n < lim);
    chk(s, 1'b1);
  endtask
  // register reset values and an unmapped address
  task automatic t_reset;
    logic [7:0] a[7] = '{`ACS_OFS_LEN, `ACS_OFS_RATE, `ACS_OFS_G13,
      `ACS_OFS_OFF3, `ACS_OFS_CTRL, `ACS_OFS_RES, 8'h18};
    logic [7:0] e[7] = '{8'h28, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 7; k++) rchk(a[k], e[k], k == 6);
    chk(stage2_gain, 4'h1);
    chk(stage3_gain, 7'h0C);
    $display("test reset done");
  endtask
  // one conversion per rate code, checking decode and sequence
  task automatic t_conv(input int i);
    logic [1:0] c;
    logic [3:0] g2t[4] = '{4'h1, 4'h2, 4'h5, 4'hA};
    logic [3:0] kk;
    logic q, bg0;
    int nel, oversampling_ratio, ne, nt, dly, last, cyc, sum;
    c = 2'(i);
    nel = 1 << i;
    oversampling_ratio = 8 << (i % 2);
    slow <= i[0];
    wr(`ACS_OFS_RATE, {c, c, i[0], 3'h5});
    wr(`ACS_OFS_G13, {i[0], i[0] ? 7'h7F : 7'h06});
    wr(`ACS_OFS_OFF3, {1'b0, i[0], 6'h3F});
    wr(`ACS_OFS_CTRL, {6'h00, c});
    wr(`ACS_OFS_LEN, {1'b1, c, 2'b00, i[0], 2'b00});
    wait_on(0, 10);
    @(negedge pclk);
    chk(stage1_x10, i[0]);
    chk(stage2_gain, g2t[c]);
    chk({stage2_off_neg, stage2_off_mag}, {i[0], 3'h5});
    chk(stage3_gain, i[0] ? 7'h7F : 7'h06);
    chk({stage3_off_neg, stage3_off_mag}, {i[0], 6'h3F});
    wr(`ACS_OFS_G13, 8'h00);
    @(negedge pclk);
    chk(stage3_gain, i[0] ? 7'h7F : 7'h06);
    rchk(`ACS_OFS_CTRL, {24'h0, 6'h20, c}, 1'b0);
    ne = 0; nt = 0; dly = -1; q = 0; last = -1; cyc = 0; bg0 = 0;
    while (conv_done !== 1'b1) begin
      @(negedge pclk);
      cyc++;
      if (fs_tick === 1'b1) begin
        if (ne > 0 && !q) nt++;
        if (last >= 0) chk((cyc - last - (800 >> i) + 1) inside {[0:2]}, 1);
        last = cyc;
      end
      if (quant_go === 1'b1) q = 1'b1;
      if (elem_begin === 1'b1) begin
        ne++;
        dly = 3;
      end else if (dly > 0) dly--;
      else if (dly == 0) begin
        kk = 4'(ne - 1);
        if (ne == 1) bg0 = bandgap_hi;
        chk(chop_pol, kk[0]);
        chk(bandgap_hi, c[1] ? bg0 ^ (c[0] ? kk[1] : kk[0]) : c[0]);
        dly = -1;
      end
    end
    chk(ne, nel);
    chk(nt, nel * (oversampling_ratio + 1));
    chk(q, 1'b1);
    sum = 0;
    for (int k = 0; k < nel; k++) sum += 256 + 16 * k;
    @(negedge pclk);
    chk(result, 16'(sum >> i));
    rchk(`ACS_OFS_RES, sum >> i, 1'b0);
    rchk(`ACS_OFS_LEN, {24'h0, 1'b0, c, 2'b00, i[0], 2'b00}, 1'b0);
    rchk(`ACS_OFS_CTRL, {24'h0, 6'h00, c}, 1'b0);
    $display("test conversion %0d done", i);
  endtask
  // a start while busy waits for the running conversion
  task automatic t_queue;
    wr(`ACS_OFS_LEN, 8'h80);
    wait_on(0, 10);
    repeat (700) @(negedge pclk);
    wr(`ACS_OFS_LEN, 8'h80);
    wait_on(1, 900);
    wait_on(0, 5);
    wait_on(1, 3000);
    repeat (20) @(negedge pclk);
    chk(busy, 1'b0);
    $display("test queued start done");
  endtask
  // continuous mode restarts until cleared
  task automatic t_cont;
    wr(`ACS_OFS_LEN, 8'h02);
    wait_on(1, 3000);
    repeat (2) begin
      @(negedge pclk);
      chk(busy, 1'b1);
    end
    wait_on(1, 3000);
    wr(`ACS_OFS_LEN, 8'h00);
    wait_on(1, 3000);
    repeat (20) @(negedge pclk);
    chk(busy, 1'b0);
    $display("test continuous done");
  endtask
  // restore mid-conversion, then a reset in mid-run
  task automatic t_restore;
    wr(`ACS_OFS_G13, 8'h7F);
    wr(`ACS_OFS_LEN, 8'h80);
    wait_on(2, 400);
    wr(`ACS_OFS_CTRL, 8'h40);
    repeat (3) begin
      @(negedge pclk);
      chk(conv_done, 1'b0);
    end
    chk(busy, 1'b1);
    chk(stage3_gain, 7'h0C);
    rchk(`ACS_OFS_G13, 32'h0C, 1'b0);
    rchk(`ACS_OFS_CTRL, 32'h80, 1'b0);
    wait_on(2, 1700);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(busy, 1'b0);
    $display("test restore done");
  endtask
  // counts, verdict and end of run
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    err_total = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    for (int i = 0; i < 4; i++) t_conv(i);
    t_queue;
    t_cont;
    t_restore;
    print_verdict;
  end
  // watchdog against a hang
  initial begin
    #(90000 * 20);
    err_total++;
    print_verdict;
  end
endmodule
